// *** include/fkas_cfg.svh ***
// Offsets, field positions, reset values and counts for the flash key and array select block.
// Contract
// - Erase-select bit 0 chooses the erasing program
// - Erase-select bit clears when transfer finishes; a write in the same cycle is stored instead
// - Download request accepted only with key A5
// - Other key values never set download request
// - Programming and erasing enabled only with key 5A
// - Array select AA picks boot array, else user
// - Array select resets to AA in boot mode; reset loads 00, and AA is loaded once the straps settle
// - Boot array never programmable in user program mode
// - Download copies chosen program, then clears request
`ifndef FKAS_CFG_SVH
`define FKAS_CFG_SVH
`define FKAS_OFS_ERASE_SEL   8'h00
`define FKAS_OFS_KEY         8'h04
`define FKAS_OFS_ARRAY_SEL   8'h08
`define FKAS_OFS_DL_CTRL     8'h0c
`define FKAS_OFS_PROG_SEL    8'h10
`define FKAS_OFS_STATUS      8'h14
`define FKAS_BIT_CHOOSE      0
`define FKAS_BIT_DL_REQ      0
`define FKAS_KEY_DOWNLOAD    8'ha5
`define FKAS_KEY_PROGRAM     8'h5a
`define FKAS_ARRAY_BOOT      8'haa
`define FKAS_ARRAY_USER      8'h00
`define FKAS_RST_BYTE        8'h00
`define FKAS_COPY_CYCLES     16
`define FKAS_SYNC_STAGES     3
`endif

// *** include/fkas_pkg.sv ***
// Types shared by the flash key and array select block.
package fkas_pkg;
  typedef struct packed {
    logic user_prog;
    logic user_boot;
  } fkas_mode_t;

  typedef struct packed {
    logic user_prog;
    logic user_boot;
    logic copy_busy;
    logic boot_active;
    logic prog_enable;
  } fkas_status_t;

  typedef enum logic [1:0] {
    FKAS_IDLE = 2'b00,
    FKAS_COPY = 2'b01,
    FKAS_DONE = 2'b11
  } fkas_copy_state_t;
endpackage

// *** hdl/fkas_copier.sv ***
// Sequencer that paces the copy of an on-chip program into RAM.
`timescale 1ns/10ps
`include "fkas_cfg.svh"
module fkas_copier
  import fkas_pkg::*;
#(
  parameter int COPY_CYCLES = `FKAS_COPY_CYCLES
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  fkas_copy_state_t state_q;
  fkas_copy_state_t state_d;
  logic [15:0]      cnt_q;
  logic [15:0]      cnt_d;
  wire              last = (cnt_q == 16'(COPY_CYCLES - 1));

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      FKAS_IDLE: begin
        cnt_d = 16'h0000;
        if (start) begin
          state_d = FKAS_COPY;
        end
      end
      FKAS_COPY: begin
        cnt_d = cnt_q + 16'h0001;
        if (last) begin
          state_d = FKAS_DONE;
        end
      end
      FKAS_DONE: begin
        state_d = FKAS_IDLE;
      end
      default: begin
        state_d = FKAS_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= FKAS_IDLE;
      cnt_q   <= 16'h0000;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  assign busy = (state_q != FKAS_IDLE);
  assign done = (state_q == FKAS_DONE);
endmodule

// *** hdl/fkas_top.sv ***
// Flash key, erase-program select and array select registers behind an APB slave.
`timescale 1ns/10ps
`include "fkas_cfg.svh"
module fkas_top
  import fkas_pkg::*;
#(
  parameter int COPY_CYCLES = `FKAS_COPY_CYCLES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Mode pins and CPU state
  input  wire fkas_mode_t  mode_pins,
  input  wire logic        exec_in_ram,
  // Flash control
  output logic             prog_erase_enable,
  output logic             boot_array_active,
  output logic             copy_busy,
  output logic             copy_erase_sel,
  output logic             copy_prog_sel
);
  localparam int REQ_BOUND = COPY_CYCLES + 2;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // Mode pins pass three flops; a change is taken once the last two agree.
  fkas_mode_t sync1_q;
  fkas_mode_t sync2_q;
  fkas_mode_t sync3_q;
  fkas_mode_t mode_q;
  logic [2:0] init_cnt_q;
  logic       init_done_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      mode_q  <= '0;
    end else begin
      sync1_q <= mode_pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q) begin
        mode_q <= sync3_q;
      end
    end
  end

  // The bus stalls until the straps have settled, but a read whose setup phase comes before the load returns the reset value.
  // The filtered mode needs one edge beyond the three flops, hence the extra count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_cnt_q  <= 3'h0;
      init_done_q <= 1'b0;
    end else if (!init_done_q) begin
      init_cnt_q  <= init_cnt_q + 3'h1;
      init_done_q <= (init_cnt_q == 3'(`FKAS_SYNC_STAGES + 1));
    end
  end
  wire init_load = !init_done_q && (init_cnt_q == 3'(`FKAS_SYNC_STAGES + 1));

  // Bus decode.
  wire access    = psel && penable && pready;
  wire wr        = access && pwrite;
  wire setup_rd  = psel && !penable && !pwrite;
  wire hit_erase = hit(paddr, `FKAS_OFS_ERASE_SEL);
  wire hit_key   = hit(paddr, `FKAS_OFS_KEY);
  wire hit_array = hit(paddr, `FKAS_OFS_ARRAY_SEL);
  wire hit_ctrl  = hit(paddr, `FKAS_OFS_DL_CTRL);
  wire hit_prog  = hit(paddr, `FKAS_OFS_PROG_SEL);
  wire hit_stat  = hit(paddr, `FKAS_OFS_STATUS);
  wire mapped    = hit_erase | hit_key | hit_array | hit_ctrl | hit_prog | hit_stat;

  logic [7:0] erase_sel_q;
  logic [7:0] prog_sel_q;
  logic [7:0] key_q;
  logic [7:0] array_sel_q;
  logic       dl_req_q;
  logic       copy_done;
  logic       copy_run;

  wire key_dl   = (key_q == `FKAS_KEY_DOWNLOAD);
  wire key_prog = (key_q == `FKAS_KEY_PROGRAM);
  wire wr_erase = wr && hit_erase;
  wire wr_prog  = wr && hit_prog;
  wire wr_array = wr && hit_array && exec_in_ram;
  wire req_set  = wr && hit_ctrl && pwdata[`FKAS_BIT_DL_REQ] && key_dl && exec_in_ram
                  && !dl_req_q;

  // Select bits: a software write in the same cycle as the end of a copy wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erase_sel_q <= `FKAS_RST_BYTE;
      prog_sel_q  <= `FKAS_RST_BYTE;
    end else begin
      if (wr_erase) begin
        erase_sel_q <= pwdata[7:0];
      end else if (copy_done) begin
        erase_sel_q[`FKAS_BIT_CHOOSE] <= 1'b0;
      end
      if (wr_prog) begin
        prog_sel_q <= pwdata[7:0];
      end else if (copy_done) begin
        prog_sel_q[`FKAS_BIT_CHOOSE] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_q <= `FKAS_RST_BYTE;
    end else if (wr && hit_key) begin
      key_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      array_sel_q <= `FKAS_ARRAY_USER;
    end else if (init_load) begin
      array_sel_q <= mode_q.user_boot ? `FKAS_ARRAY_BOOT : `FKAS_ARRAY_USER;
    end else if (wr_array) begin
      array_sel_q <= pwdata[7:0];
    end
  end

  // The request bit holds for the whole copy and drops when it ends.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dl_req_q <= 1'b0;
    end else if (req_set) begin
      dl_req_q <= 1'b1;
    end else if (copy_done) begin
      dl_req_q <= 1'b0;
    end
  end

  fkas_copier #(
    .COPY_CYCLES (COPY_CYCLES)
  ) u_copier (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (req_set),
    .busy    (copy_run),
    .done    (copy_done)
  );

  // Any key byte other than an exact match grants nothing.
  assign boot_array_active = (array_sel_q == `FKAS_ARRAY_BOOT);
  assign prog_erase_enable = key_prog && !(mode_q.user_prog && boot_array_active);
  assign copy_busy         = copy_run;
  assign copy_erase_sel    = erase_sel_q[`FKAS_BIT_CHOOSE];
  assign copy_prog_sel     = prog_sel_q[`FKAS_BIT_CHOOSE];

  fkas_status_t status;
  assign status = '{user_prog: mode_q.user_prog, user_boot: mode_q.user_boot,
                    copy_busy: copy_run, boot_active: boot_array_active,
                    prog_enable: prog_erase_enable};

  // The request bit is write-only and reads as zero.
  wire [7:0] rd_mux = hit_erase ? erase_sel_q :
                      hit_key   ? key_q :
                      hit_array ? array_sel_q :
                      hit_prog  ? prog_sel_q :
                      hit_stat  ? {3'h0, status} : 8'h00;

  logic [7:0] rdata_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 8'h00;
    end else if (setup_rd) begin
      rdata_q <= rd_mux;
    end
  end

  assign prdata  = {24'h000000, rdata_q};
  assign pready  = init_done_q;
  assign pslverr = access && !mapped;

  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_req_write;
    wr && hit_ctrl && pwdata[`FKAS_BIT_DL_REQ] && exec_in_ram && !dl_req_q;
  endsequence

  property p_req_with_key;
    s_req_write and key_dl |=> dl_req_q ##1 copy_busy;
  endproperty
  a_req_with_key: assert property (p_req_with_key) else $error("request lost with key");

  property p_req_no_key;
    s_req_write and !key_dl and !dl_req_q |=> !dl_req_q;
  endproperty
  a_req_no_key: assert property (p_req_no_key) else $error("request set without key");

  property p_req_clears;
    $rose(dl_req_q) |-> ##[1:REQ_BOUND] !dl_req_q;
  endproperty
  a_req_clears: assert property (p_req_clears) else $error("request never cleared");

  property p_erase_clears;
    copy_done && !wr_erase |=> !copy_erase_sel;
  endproperty
  a_erase_clears: assert property (p_erase_clears) else $error("erase select kept");

  property p_erase_write;
    wr_erase |=> copy_erase_sel == $past(pwdata[0]);
  endproperty
  a_erase_write: assert property (p_erase_write) else $error("erase select not stored");

  property p_key_gate;
    !key_prog |-> !prog_erase_enable;
  endproperty
  a_key_gate: assert property (p_key_gate) else $error("enable without key");

  property p_array_switch;
    wr_array |=> boot_array_active == ($past(pwdata[7:0]) == `FKAS_ARRAY_BOOT);
  endproperty
  a_array_switch: assert property (p_array_switch) else $error("array not switched");

  property p_array_init;
    init_load |=> array_sel_q == ($past(mode_q.user_boot) ? 8'haa : 8'h00);
  endproperty
  a_array_init: assert property (p_array_init) else $error("array select init wrong");

  property p_boot_guard;
    mode_q.user_prog && boot_array_active |-> !prog_erase_enable;
  endproperty
  a_boot_guard: assert property (p_boot_guard) else $error("boot array writable");

  property p_key_exact;
    key_q != 8'h5a |-> !prog_erase_enable;
  endproperty
  a_key_exact: assert property (p_key_exact) else $error("partial key accepted");
endmodule

// *** testbench/fkas_cpu.sv ***
// CPU software model running from on-chip RAM, acting as APB master.
`timescale 1ns/10ps
module fkas_cpu (
  // Clock
  input  wire logic        pclk,
  // APB master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // CPU state
  output logic             exec_in_ram
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    exec_in_ram = 1'b1;
  end

  // Called just after a rising edge; the extra edge at the end keeps back-to-back calls apart.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic set_ram(input logic b);
    exec_in_ram <= b;
    @(posedge pclk);
  endtask

  // The key goes in before the request, as the software sequence demands.
  task automatic download(output logic [31:0] r, output logic e);
    xfer(1'b1, 8'h04, 32'ha5, r, e);
    xfer(1'b1, 8'h0c, 32'h1, r, e);
  endtask
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for the flash key and array select block.
`timescale 1ns/10ps
module tb_top import fkas_pkg::*;;
  localparam int CC = 2;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  fkas_mode_t  mode_pins = '0;
  logic        psel, penable, pwrite, pready, pslverr, exec_in_ram;
  logic [7:0]  paddr, k;
  logic [31:0] pwdata, prdata, r;
  logic        prog_erase_enable, boot_array_active, copy_busy, copy_erase_sel, copy_prog_sel;
  logic        e;
  int          mismatches = 0;
  int          total_checks = 0;
  int          n, busy_n;

  always #20 pclk = ~pclk;
  always @(posedge pclk) if (copy_busy === 1'b1) busy_n++;

  fkas_top #(.COPY_CYCLES(CC)) fkas_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .mode_pins, .exec_in_ram, .prog_erase_enable,
    .boot_array_active, .copy_busy, .copy_erase_sel, .copy_prog_sel);
  fkas_cpu fkas_cpu_i (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .exec_in_ram);

  function automatic logic exp_en(input logic [7:0] key, input logic boot, input logic up);
    return key == 8'h5a && !(up && boot);
  endfunction

  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    fkas_cpu_i.xfer(1'b1, a, {24'h0, d}, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    fkas_cpu_i.xfer(1'b0, a, 32'h0, r, e);
    chk(r === {24'h0, x} && e === 1'b0, "read value");
  endtask

  task automatic do_reset(input logic boot);
    presetn <= 1'b0;
    mode_pins <= {1'b0, boot};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    close_out();
  end

  initial begin
    void'($urandom(11));
    do_reset(1'b1);
    rd(8'h08, 8'haa);
    chk(boot_array_active === 1'b1, "boot array after reset");
    rd(8'h04, 8'h00);
    do_reset(1'b0);
    rd(8'h08, 8'h00);
    // Exact key, every single-bit neighbour of it, the download key and random keys.
    for (int i = 0; i < 24; i++) begin
      k = (i == 0) ? 8'h5a : (i == 1) ? 8'ha5 : (i < 10) ? 8'h5a ^ (8'h01 << (i - 2))
        : 8'($urandom());
      wr(8'h04, k);
      chk(prog_erase_enable === exp_en(k, 1'b0, 1'b0), "program enable");
      rd(8'h04, k);
    end
    for (int i = 0; i < 12; i++) begin
      k = (i % 3 == 0) ? 8'haa : (i == 1) ? 8'hab : 8'($urandom());
      wr(8'h08, k);
      chk(boot_array_active === (k == 8'haa), "array select");
    end
    wr(8'h08, 8'h00);
    fkas_cpu_i.set_ram(1'b0);
    wr(8'h08, 8'haa);
    chk(boot_array_active === 1'b0, "array write outside RAM");
    fkas_cpu_i.set_ram(1'b1);
    wr(8'h08, 8'haa);
    wr(8'h04, 8'h5a);
    mode_pins <= 2'b10;
    repeat (10) @(posedge pclk);
    chk(prog_erase_enable === exp_en(8'h5a, 1'b1, 1'b1), "boot array locked");
    wr(8'h08, 8'h00);
    chk(prog_erase_enable === exp_en(8'h5a, 1'b0, 1'b1), "user array open");
    wr(8'h00, 8'h01);
    wr(8'h10, 8'h01);
    chk(copy_erase_sel === 1'b1 && copy_prog_sel === 1'b1, "selects");
    wr(8'h04, 8'ha4);
    busy_n = 0;
    wr(8'h0c, 8'h01);
    repeat (CC + 8) @(posedge pclk);
    chk(busy_n == 0 && copy_erase_sel === 1'b1, "request refused");
    fkas_cpu_i.download(r, e);
    repeat (CC + 8) @(posedge pclk);
    chk(busy_n == CC + 1, "copy length");
    chk(copy_erase_sel === 1'b0 && copy_prog_sel === 1'b0, "selects cleared");
    rd(8'h00, 8'h00);
    rd(8'h0c, 8'h00);
    rd(8'h14, 8'h10);
    fkas_cpu_i.xfer(1'b0, 8'h20, 32'h0, r, e);
    chk(e === 1'b1 && r === 32'h0, "unmapped address");
    close_out();
  end
endmodule
